// ### dv/spcp_props.sv
// concurrent checks on the link between host end and device end
`timescale 1ns/1ps
module spcp_props #(
  parameter int POR_CYCLES = spcp_pkg::POR_CYC,
  parameter int LOAD_BYTES = spcp_pkg::LOAD_BYTES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reload_request_n,
  input wire logic cfg_clock,
  input wire logic [spcp_pkg::DATA_W-1:0] cfg_data,
  input wire logic init_state_n,
  input wire logic load_complete
);
  logic [16:0] low_reg;
  logic [16:0] req_hi_reg;
  logic [7:0] rise_reg;
  logic por_reg;
  logic clk_reg;

  // saturating wait counter so a long user-mode stay cannot wrap
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      low_reg <= 17'h0;
      req_hi_reg <= 17'h0;
      rise_reg <= 8'h0;
      por_reg <= 1'b0;
      clk_reg <= 1'b0;
    end
    else
    begin
      clk_reg <= cfg_clock;
      por_reg <= por_reg | init_state_n;
      low_reg <= init_state_n ? 17'h0 : low_reg + 17'h1;
      req_hi_reg <= !reload_request_n ? 17'h0 : req_hi_reg + {16'h0, req_hi_reg != 17'h1FFFF};
      rise_reg <= !reload_request_n ? 8'h0 : rise_reg + {7'h0, cfg_clock && !clk_reg};
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence req_held_s;
    (!reload_request_n)[*8];
  endsequence
  sequence clock_still_s;
    $stable(cfg_clock)[*8];
  endsequence

  req_answer_a: assert property ($fell(reload_request_n) |-> ##[1:8] !init_state_n && !load_complete)
    else $error("status or done not low after request");
  req_holds_a: assert property (req_held_s |-> !init_state_n && !load_complete)
    else $error("lines high while request held low");
  por_delay_a: assert property ($rose(init_state_n) && !por_reg |-> low_reg >= POR_CYCLES - 1)
    else $error("status released before power-on delay");
  status_pulse_a: assert property ($rose(init_state_n) && por_reg |->
    low_reg >= spcp_pkg::STATUS_MIN_CYC && low_reg <= 17'h3E8)
    else $error("status low pulse out of range");
  status_release_a: assert property ($rose(reload_request_n) |-> ##[0:1000] init_state_n)
    else $error("status not released after request high");
  user_lines_a: assert property (load_complete && reload_request_n |-> init_state_n)
    else $error("status low while done high");
  done_after_load_a: assert property ($rose(load_complete) |-> rise_reg == 4 * LOAD_BYTES)
    else $error("done rose at wrong clock count");
  clock_steady_a: assert property ($rose(load_complete) |-> ##8 clock_still_s)
    else $error("link clock moved after done");
  first_edge_a: assert property ($rose(cfg_clock) && rise_reg == 8'h0 |-> req_hi_reg >= 17'h3E8)
    else $error("first link clock edge too early");
  data_setup_a: assert property ($rose(cfg_clock) |-> $stable(cfg_data) ##1 $stable(cfg_data))
    else $error("data moved around link clock rise");
  req_width_a: assert property ($rose(reload_request_n) |-> $past(reload_request_n, 20) == 1'b0)
    else $error("request pulse too short");
endmodule : spcp_props

// ### dv/testbench.sv
// bench: host and device pair, plus a second device driven by the bench
`timescale 1ns/1ps
module testbench;
  localparam int NB = 6;
  localparam int PORC = 50;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start = 1'b0;
  logic wr_valid = 1'b0;
  logic use_uclk = 1'b0;
  logic uclk = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready, busy, done, bv1, bv2, ld1, ld2, um1, um2, io1, io2;
  logic [7:0] b1, b2;
  logic [7:0] got1[$];
  logic [7:0] got2[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  spcp_link_if l1();
  spcp_link_if l2();
  wire [5:0] mon = {l2.init_state_n, l2.load_complete, ld1, um1, done, ld2};

  spcp_host #(.LOAD_BYTES(NB)) spcp_host_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .link(l1.host), .start_in(start), .wr_data_in(wr_data), .wr_valid_in(wr_valid),
    .wr_ready_out(wr_ready), .busy_out(busy), .done_out(done));
  spcp_device #(.POR_CYCLES(PORC), .LOAD_BYTES(NB)) spcp_device_i (.mclk_in(mclk_in),
    .rst_in(rst_in), .link(l1.dev), .use_user_clk_in(use_uclk), .user_init_clock_in(uclk),
    .byte_out(b1), .byte_valid_out(bv1), .loaded_out(ld1), .user_mode_out(um1),
    .io_release_out(io1));
  spcp_device #(.POR_CYCLES(PORC), .LOAD_BYTES(NB)) spcp_device_2_i (.mclk_in(mclk_in),
    .rst_in(rst_in), .link(l2.dev), .use_user_clk_in(1'b0), .user_init_clock_in(uclk),
    .byte_out(b2), .byte_valid_out(bv2), .loaded_out(ld2), .user_mode_out(um2),
    .io_release_out(io2));
  spcp_props #(.POR_CYCLES(PORC), .LOAD_BYTES(NB)) spcp_props_i (.mclk_in(mclk_in),
    .rst_in(rst_in), .reload_request_n(l1.reload_request_n), .cfg_clock(l1.cfg_clock),
    .cfg_data(l1.cfg_data), .init_state_n(l1.init_state_n),
    .load_complete(l1.load_complete));

  always #50 mclk_in = ~mclk_in;
  // user init clock free running, period four times that of the system clock
  always #200 uclk = ~uclk;

  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask : report_and_stop

  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (bv1 === 1'b1)
      got1.push_back(b1);
    if (bv2 === 1'b1)
      got2.push_back(b2);
    if (cyc == 40000)
    begin
      $display("Error at %0t: timeout", $time);
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask : chk

  function automatic logic [7:0] pat(input int i);
    return 8'hA5 + 8'h1D * i[7:0];
  endfunction : pat

  // ready judged at the falling edge, taken at the next rise
  task automatic wr(input logic [7:0] d);
  begin
    wr_data <= d;
    wr_valid <= 1'b1;
    @(negedge mclk_in);
    while (wr_ready !== 1'b1)
      @(negedge mclk_in);
    @(posedge mclk_in);
  end
  endtask : wr

  task automatic wait_bit(input int k, input logic v, output int n);
  begin
    n = 0;
    while (mon[k] !== v && n < 3000)
    begin
      @(posedge mclk_in);
      n++;
    end
  end
  endtask : wait_bit

  task automatic cmpq(input int base, input logic [7:0] q[$]);
  begin
    chk(q.size(), NB);
    for (int i = 0; i < NB; i++)
      chk(q[i], pat(base + i));
  end
  endtask : cmpq

  task automatic rise2(input logic [7:0] d);
  begin
    l2.cfg_data <= d;
    repeat (4) @(posedge mclk_in);
    l2.cfg_clock <= 1'b1;
    repeat (4) @(posedge mclk_in);
    l2.cfg_clock <= 1'b0;
  end
  endtask : rise2

  // three filler rises carry inverted data that must not latch
  task automatic send2(input logic [7:0] d);
  begin
    rise2(d);
    repeat (3) rise2(~d);
  end
  endtask : send2

  task automatic reload2;
    int n;
  begin
    l2.reload_request_n <= 1'b0;
    repeat (8) @(posedge mclk_in);
    chk({l2.init_state_n, l2.load_complete}, 32'h0);
    repeat (12) @(posedge mclk_in);
    l2.reload_request_n <= 1'b1;
    wait_bit(5, 1'b1, n);
    chk(n >= 80 && n <= 1000, 32'h1);
    got2.delete();
    repeat (1000) @(posedge mclk_in);
  end
  endtask : reload2

  initial
  begin
    int n;
    l2.reload_request_n = 1'b1;
    l2.cfg_clock = 1'b0;
    l2.cfg_data = 8'h00;
    l2.cfg_data_oe = 1'b1;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (60) @(posedge mclk_in);
    for (int i = 0; i < 4; i++)
      wr(pat(i));
    wr_valid <= 1'b0;
    @(negedge mclk_in);
    chk(wr_ready, 32'h0);
    @(posedge mclk_in);
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    repeat (1600) @(posedge mclk_in);
    chk({busy, ld1, um1, io1, l1.load_complete}, 32'h10);
    wr(pat(4));
    wr(pat(5));
    wr_valid <= 1'b0;
    wait_bit(3, 1'b1, n);
    cmpq(0, got1);
    wait_bit(2, 1'b1, n);
    chk(n >= 199 && n <= 1000, 32'h1);
    chk({io1, done, l1.cfg_data_oe}, 32'h6);
    chk({l1.reload_request_n, l1.init_state_n, l1.load_complete}, 32'h7);
    $display("test host load done");
    use_uclk <= 1'b1;
    got1.delete();
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    repeat (12) @(posedge mclk_in);
    chk({um1, io1, l1.load_complete, l1.init_state_n}, 32'h0);
    for (int i = 0; i < NB; i++)
      wr(pat(8 + i));
    wr_valid <= 1'b0;
    wait_bit(3, 1'b1, n);
    cmpq(8, got1);
    wait_bit(2, 1'b1, n);
    chk(n >= 1190 && n <= 1215, 32'h1);
    $display("test reload with user clock done");
    reload2();
    send2(pat(20));
    send2(pat(21));
    rise2(8'h00);
    reload2();
    send2(pat(0));
    send2(pat(1));
    // pause with the next byte already on the pins
    l2.cfg_data <= pat(2);
    repeat (200) @(posedge mclk_in);
    for (int i = 2; i < NB - 1; i++)
      send2(pat(i));
    rise2(pat(NB - 1));
    rise2(8'h00);
    rise2(8'h00);
    repeat (6) @(posedge mclk_in);
    chk({ld2, l2.load_complete}, 32'h0);
    rise2(8'h00);
    repeat (6) @(posedge mclk_in);
    chk({ld2, l2.load_complete}, 32'h3);
    cmpq(0, got2);
    repeat (250) @(posedge mclk_in);
    chk({um2, io2}, 32'h3);
    $display("test driven device done");
    report_and_stop();
  end
endmodule : testbench

// ### rtl/spcp_device.sv
// device end: byte latch, reload handshake, status lines and user-mode entry
//
// Contract
// R1: host runs three clock cycles past last latch
// R2: host drives next byte before resume edge
// R3: user mode: request, status, done all high
// R4: request low starts a new load cycle
// R5: status and done low within 800 ns
// R6: status low during power-on reset delay
// R7: done stays low until configuration finishes
// R8: host holds clock steady after completion
// R9: data pins become user I/O when done; io_release_out rises only in user mode
// R10: host holds request low at least 2 us
// R11: status low pulse lasts 10 to 100
// R12: status released within 100 after request high
// R13: host waits 100 us before first edge
// R14: host waits 2 us after status high
// R15: internal clock: user mode 20-100 us later
// R16: user clock: 4 periods plus 299 cycles
// R17: byte latched on first then every fourth edge
// R18: host clock four times byte rate, 100 MHz max
// R19: held clock pauses load, state kept
// R20: new cycle restarts the byte phase counter
`timescale 1ns/1ps
module spcp_device #(
  parameter int POR_CYCLES = spcp_pkg::POR_CYC,
  parameter int LOAD_BYTES = spcp_pkg::LOAD_BYTES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  spcp_link_if.dev link,
  input wire logic use_user_clk_in,
  input wire logic user_init_clock_in,
  output logic [spcp_pkg::DATA_W-1:0] byte_out,
  output logic byte_valid_out,
  output logic loaded_out,
  output logic user_mode_out,
  output logic io_release_out
);
  localparam int CW = spcp_pkg::CNT_W;
  localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
  localparam logic [CW-1:0] STATUS_MIN = CW'(spcp_pkg::STATUS_MIN_CYC);
  localparam logic [CW-1:0] CD2UM = CW'(spcp_pkg::CD2UM_CYC);
  localparam logic [CW-1:0] CD2CU = CW'(spcp_pkg::CD2CU_CYC);
  localparam logic [8:0] USER_PERIODS = 9'(spcp_pkg::USER_CLK_PERIODS);
  localparam logic [7:0] BYTES = 8'(LOAD_BYTES);

  typedef struct packed {
    spcp_pkg::spcp_dev_state_t state;
    logic [CW-1:0] cnt;
    logic [8:0] ucnt;
    logic [1:0] phase;
    logic [7:0] nbytes;
    logic rq1;
    logic rq2;
    logic ck1;
    logic ck2;
    logic ck3;
    logic uc1;
    logic uc2;
    logic uc3;
    logic [spcp_pkg::DATA_W-1:0] d1;
    logic [spcp_pkg::DATA_W-1:0] d2;
    logic [spcp_pkg::DATA_W-1:0] data;
    logic strobe;
  } spcp_dev_regs_t;

  spcp_dev_regs_t r_reg;
  spcp_dev_regs_t r_next;

  function automatic logic rose(input logic now_lvl, input logic old_lvl);
    rose = now_lvl && !old_lvl;
  endfunction : rose

  always_comb
  begin
    r_next = r_reg;
    r_next.rq1 = link.reload_request_n;
    r_next.rq2 = r_reg.rq1;
    r_next.ck1 = link.cfg_clock;
    r_next.ck2 = r_reg.ck1;
    r_next.ck3 = r_reg.ck2;
    r_next.d1 = link.cfg_data;
    r_next.d2 = r_reg.d1;
    r_next.uc1 = user_init_clock_in;
    r_next.uc2 = r_reg.uc1;
    r_next.uc3 = r_reg.uc2;
    r_next.strobe = 1'b0;
    case (r_reg.state)
      spcp_pkg::D_POR:
      begin
        // the request line is not looked at until the delay has run
        if (r_reg.cnt >= POR_LAST)
        begin
          r_next.state = spcp_pkg::D_LOAD; // [R6]
          r_next.cnt = '0;
        end
        else
        begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      spcp_pkg::D_RST:
      begin
        // pulse is at least the minimum even for a short request
        if (r_reg.cnt != '1)
        begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
        if (r_reg.rq2 && r_reg.cnt >= STATUS_MIN)
        begin
          r_next.state = spcp_pkg::D_LOAD; // [R11] [R12]
          r_next.cnt = '0;
        end
      end
      spcp_pkg::D_LOAD:
      begin
        // no edge, no change: a held clock freezes the load
        if (rose(r_reg.ck2, r_reg.ck3)) // [R19]
        begin
          if (r_reg.phase == spcp_pkg::LATCH_PHASE && r_reg.nbytes != BYTES)
          begin
            r_next.data = r_reg.d2; // [R17]
            r_next.strobe = 1'b1;
            r_next.nbytes = r_reg.nbytes + 1'b1;
          end
          r_next.phase = r_reg.phase + 1'b1; // [R17]
          // last byte needs three more edges to be processed
          if (r_reg.nbytes == BYTES && r_reg.phase == spcp_pkg::LAST_PHASE)
          begin
            r_next.state = spcp_pkg::D_INIT; // [R7]
            r_next.cnt = '0;
            r_next.ucnt = '0;
          end
        end
      end
      spcp_pkg::D_INIT:
      begin
        if (use_user_clk_in)
        begin
          if (r_reg.cnt < CD2CU)
          begin
            r_next.cnt = r_reg.cnt + 1'b1; // [R16]
          end
          else if (rose(r_reg.uc2, r_reg.uc3))
          begin
            r_next.ucnt = r_reg.ucnt + 1'b1;
            if (r_reg.ucnt == USER_PERIODS - 9'h001)
            begin
              r_next.state = spcp_pkg::D_USER; // [R16]
            end
          end
        end
        else
        begin
          // least figure taken, well under the 100 us ceiling
          if (r_reg.cnt >= CD2UM - 1'b1)
          begin
            r_next.state = spcp_pkg::D_USER; // [R15]
          end
          else
          begin
            r_next.cnt = r_reg.cnt + 1'b1;
          end
        end
      end
      spcp_pkg::D_USER:
      begin
        r_next.cnt = r_reg.cnt;
      end
      default:
      begin
        r_next.state = spcp_pkg::D_POR;
        r_next.cnt = '0;
      end
    endcase
    // any falling request outside power-on reset and the D_RST pulse restarts the load
    if (!r_reg.rq2 && r_reg.state != spcp_pkg::D_POR && r_reg.state != spcp_pkg::D_RST)
    begin
      r_next.state = spcp_pkg::D_RST; // [R4] [R5]
      r_next.cnt = '0;
      r_next.phase = spcp_pkg::LATCH_PHASE; // [R20]
      r_next.nbytes = '0;
      r_next.strobe = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r_reg <= '0;
      r_reg.state <= spcp_pkg::D_POR;
      r_reg.rq1 <= 1'b1;
      r_reg.rq2 <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // status low in reset phases; done low until the load ends
  assign link.init_state_n_o = 1'b0;
  assign link.init_state_n_oe = (r_reg.state == spcp_pkg::D_POR) ||
                                (r_reg.state == spcp_pkg::D_RST); // [R5] [R6] [R11]
  assign link.load_complete_o = 1'b0;
  assign link.load_complete_oe = (r_reg.state == spcp_pkg::D_POR) ||
                                 (r_reg.state == spcp_pkg::D_RST) ||
                                 (r_reg.state == spcp_pkg::D_LOAD); // [R7] [R3]

  assign byte_out = r_reg.data;
  assign byte_valid_out = r_reg.strobe;
  assign loaded_out = (r_reg.state == spcp_pkg::D_INIT) || (r_reg.state == spcp_pkg::D_USER);
  assign user_mode_out = (r_reg.state == spcp_pkg::D_USER); // [R3]
  assign io_release_out = (r_reg.state == spcp_pkg::D_USER); // [R9]
endmodule : spcp_device

// ### rtl/spcp_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module spcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spcp_fifo_regs_t;

  spcp_fifo_regs_t r_reg;
  spcp_fifo_regs_t r_next;
  logic full;
  logic empty;

  assign empty = (r_reg.wp == r_reg.rp);
  assign full = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && (r_reg.wp[AW] != r_reg.rp[AW]);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = r_reg.mem[r_reg.rp[AW-1:0]];

  always_comb
  begin
    r_next = r_reg;
    if (wr_valid_in && !full)
    begin
      r_next.mem[r_reg.wp[AW-1:0]] = wr_data_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (rd_ready_in && !empty)
    begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
endmodule : spcp_fifo

// ### rtl/spcp_host.sv
// host end: reload pulse, clock generation with pausing, byte feed from a fifo
`timescale 1ns/1ps
module spcp_host #(
  parameter int LOAD_BYTES = spcp_pkg::LOAD_BYTES,
  parameter int FIFO_DEPTH = spcp_pkg::FIFO_DEPTH
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  spcp_link_if.host link,
  input wire logic start_in,
  input wire logic [spcp_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic busy_out,
  output logic done_out
);
  localparam int CW = spcp_pkg::CNT_W;
  localparam logic [CW-1:0] CFG_MIN = CW'(spcp_pkg::CFG_MIN_CYC);
  localparam logic [CW-1:0] CF2CK = CW'(spcp_pkg::CF2CK_CYC);
  localparam logic [CW-1:0] ST2CK = CW'(spcp_pkg::ST2CK_CYC);
  localparam logic [2:0] HALF_LAST = 3'(spcp_pkg::HALF_PERIOD_CYC - 1);
  localparam logic [7:0] BYTES = 8'(LOAD_BYTES);

  typedef struct packed {
    spcp_pkg::spcp_host_state_t state;
    logic [CW-1:0] cnt;
    logic [2:0] div;
    logic ck;
    logic [1:0] phase;
    logic [7:0] nbytes;
    logic have;
    logic [spcp_pkg::DATA_W-1:0] data;
    logic st1;
    logic st2;
    logic cd1;
    logic cd2;
  } spcp_host_regs_t;

  spcp_host_regs_t r_reg;
  spcp_host_regs_t r_next;
  logic [spcp_pkg::DATA_W-1:0] f_data;
  logic f_valid;
  logic f_pop;

  spcp_fifo #(
    .WIDTH(spcp_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_data_in(wr_data_in),
    .wr_valid_in(wr_valid_in),
    .wr_ready_out(wr_ready_out),
    .rd_data_out(f_data),
    .rd_valid_out(f_valid),
    .rd_ready_in(f_pop)
  );

  // fetch the next byte only while the clock is low before a latch edge
  assign f_pop = (r_reg.state == spcp_pkg::H_LOAD) && !r_reg.ck && !r_reg.have &&
                 (r_reg.phase == spcp_pkg::LATCH_PHASE) && (r_reg.nbytes != BYTES);

  always_comb
  begin
    r_next = r_reg;
    r_next.st1 = link.init_state_n;
    r_next.st2 = r_reg.st1;
    r_next.cd1 = link.load_complete;
    r_next.cd2 = r_reg.cd1;
    case (r_reg.state)
      spcp_pkg::H_IDLE, spcp_pkg::H_DONE:
      begin
        if (start_in)
        begin
          r_next.state = spcp_pkg::H_PULSE; // [R4]
          r_next.cnt = '0;
        end
      end
      spcp_pkg::H_PULSE:
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (r_reg.cnt >= CFG_MIN - 1'b1)
        begin
          r_next.state = spcp_pkg::H_WAIT; // [R10]
          r_next.cnt = '0;
        end
      end
      spcp_pkg::H_WAIT:
      begin
        // count from status high, which itself follows request high
        if (!r_reg.st2)
        begin
          r_next.cnt = '0;
        end
        else if (r_reg.cnt >= CF2CK && r_reg.cnt >= ST2CK)
        begin
          r_next.state = spcp_pkg::H_LOAD; // [R13] [R14]
          r_next.div = '0;
          r_next.phase = spcp_pkg::LATCH_PHASE;
          r_next.nbytes = '0;
          r_next.have = 1'b0;
        end
        else
        begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      spcp_pkg::H_LOAD:
      begin
        if (f_pop && f_valid)
        begin
          r_next.data = f_data; // [R2]
          r_next.have = 1'b1;
          r_next.nbytes = r_reg.nbytes + 1'b1;
        end
        if (!r_reg.ck && r_reg.phase == spcp_pkg::LATCH_PHASE && r_reg.nbytes == BYTES &&
            !r_reg.have)
        begin
          r_next.state = spcp_pkg::H_FIN; // [R1] [R8]
        end
        else if (!r_reg.ck && r_reg.phase == spcp_pkg::LATCH_PHASE && !r_reg.have)
        begin
          // paused: only three edges ran past the last latched byte
          r_next.div = '0; // [R1] [R19]
        end
        else if (r_reg.div == HALF_LAST)
        begin
          r_next.div = '0;
          r_next.ck = !r_reg.ck; // [R18]
          if (!r_reg.ck)
          begin
            r_next.phase = r_reg.phase + 1'b1;
            if (r_reg.phase == spcp_pkg::LATCH_PHASE)
            begin
              r_next.have = 1'b0;
            end
          end
        end
        else
        begin
          r_next.div = r_reg.div + 1'b1;
        end
      end
      spcp_pkg::H_FIN:
      begin
        if (r_reg.cd2)
        begin
          r_next.state = spcp_pkg::H_DONE;
        end
      end
      default:
      begin
        r_next.state = spcp_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r_reg <= '0;
      r_reg.state <= spcp_pkg::H_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign link.reload_request_n = (r_reg.state != spcp_pkg::H_PULSE);
  assign link.cfg_clock = r_reg.ck; // [R8]
  assign link.cfg_data = r_reg.data;
  assign link.cfg_data_oe = (r_reg.state == spcp_pkg::H_WAIT) ||
                            (r_reg.state == spcp_pkg::H_LOAD);
  assign busy_out = (r_reg.state != spcp_pkg::H_IDLE) && (r_reg.state != spcp_pkg::H_DONE);
  assign done_out = (r_reg.state == spcp_pkg::H_DONE);
endmodule : spcp_host

// ### rtl/spcp_link_if.sv
// link between the host and the configured device, with wired open lines
`timescale 1ns/1ps
interface spcp_link_if;
  logic reload_request_n;
  logic cfg_clock;
  logic [spcp_pkg::DATA_W-1:0] cfg_data;
  logic cfg_data_oe;
  logic init_state_n_o;
  logic init_state_n_oe;
  logic load_complete_o;
  logic load_complete_oe;
  logic init_state_n;
  logic load_complete;

  // open lines with pull-ups: low only while an end drives low
  assign init_state_n = !(init_state_n_oe && !init_state_n_o);
  assign load_complete = !(load_complete_oe && !load_complete_o);

  modport dev (
    input reload_request_n,
    input cfg_clock,
    input cfg_data,
    output init_state_n_o,
    output init_state_n_oe,
    output load_complete_o,
    output load_complete_oe
  );

  modport host (
    output reload_request_n,
    output cfg_clock,
    output cfg_data,
    output cfg_data_oe,
    input init_state_n,
    input load_complete
  );
endinterface : spcp_link_if

// ### rtl/spcp_pkg.sv
// shared constants and state types of the secure parallel configuration port
package spcp_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DATA_W = 8;
  localparam int LOAD_BYTES = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 17;
  // power-on reset delay, least figure
  localparam int POR_MS = 12;
  localparam int POR_CYC = (POR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // request low to status and done low, longest figure
  localparam int CF2ST_MAX_NS = 800;
  localparam int CF2ST_CYC = CF2ST_MAX_NS / CLK_PERIOD_NS;
  // status low pulse, units taken as microseconds
  localparam int STATUS_MIN_US = 10;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_MIN_US = 2;
  localparam int CFG_MIN_CYC = (CFG_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CF2CK_MIN_US = 100;
  localparam int CF2CK_CYC = (CF2CK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST2CK_MIN_US = 2;
  localparam int ST2CK_CYC = (ST2CK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CD2UM_MIN_US = 20;
  localparam int CD2UM_CYC = (CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // four shortest configuration clock periods before the user clock is used
  localparam int CFG_CLK_MIN_PERIOD_NS = 10;
  localparam int CD2CU_NS = 4 * CFG_CLK_MIN_PERIOD_NS;
  localparam int CD2CU_CYC = (CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_CLK_PERIODS = 299;
  localparam logic [1:0] LATCH_PHASE = 2'h0;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  // host clock divider: half period in system clocks, 800 ns period
  localparam int HALF_PERIOD_CYC = 4;

  typedef enum logic [2:0] {
    D_POR = 3'h0,
    D_RST = 3'h1,
    D_LOAD = 3'h2,
    D_INIT = 3'h3,
    D_USER = 3'h4
  } spcp_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_PULSE = 3'h1,
    H_WAIT = 3'h2,
    H_LOAD = 3'h3,
    H_FIN = 3'h4,
    H_DONE = 3'h5
  } spcp_host_state_t;
endpackage : spcp_pkg
